// ===== core/mebp_pkg.sv
// constants, enums and timing of the external bus port of an 8-bit microcontroller
// assumes one clock clk_i that stands for the oscillator, 15 of them per machine cycle
// Contract
// RULE1: test zero level available for conditional jumps
// RULE2: clock enable op drives clock on test zero
// RULE3: single step low halts after each instruction
// RULE4: low interrupt pin requests interrupt, is testable
// RULE5: select high forces all fetches external
// RULE6: read strobe on data read, bus input
// RULE7: code fetch strobe reads external program bytes
// RULE8: write strobe on data write, bus output
// RULE9: one address latch pulse per machine cycle
// RULE10: bidirectional bus, bus output value stays latched
// RULE11: fetch puts low pc with latch pulse
// RULE12: data access puts address, then strobes data
// RULE13: quasi ports reset to ones, read after ones
// RULE14: external fetch drives pc top nibble on port2
// RULE15: port2 low nibble is expander bus
// RULE16: expander strobe times expander nibble transfers
// RULE17: test one testable, edges clock event counter
// RULE18: strobes exclusive, bus released during reads
package mebp_pkg;

   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned CYCLE_LEN      = 15;
   localparam logic [3:0]  CNT_LAST       = 4'hE;
   localparam logic [3:0]  CNT_DECIDE     = 4'hD;
   localparam logic [3:0]  ALE_END        = 4'h4;
   localparam logic [3:0]  ADDR_END       = 4'h5;
   localparam logic [3:0]  STB_ON         = 4'h6;
   localparam logic [3:0]  STB_OFF        = 4'hD;
   localparam logic [3:0]  SAMPLE_AT      = 4'hC;
   localparam logic [11:0] INT_ROM_LIMIT  = 12'h800;
   localparam logic [7:0]  PORT_RESET     = 8'hFF;
   localparam logic [1:0]  EXP_CMD_READ   = 2'h0;
   localparam int unsigned CLKOUT_DIV_DEF = 3;

   typedef enum logic [2:0] {
      MEBP_OP_IDLE,
      MEBP_OP_FETCH,
      MEBP_OP_DATA_RD,
      MEBP_OP_DATA_WR,
      MEBP_OP_BUS_IN,
      MEBP_OP_BUS_OUT,
      MEBP_OP_EXP
   } mebp_op_type;

   typedef enum logic {
      MEBP_ST_RUN,
      MEBP_ST_HALT
   } mebp_state_type;

endpackage

// ===== core/mebp_external_bus_port.sv
// machine-cycle sequencer for the external memory, port and expander pins
// assumes a core that posts one request per machine cycle and drives inputs synchronously
`timescale 1ns/1ps
module mebp_external_bus_port
   import mebp_pkg::*;
#(
   parameter int unsigned CLKOUT_DIV = CLKOUT_DIV_DEF
) (
   input  wire logic        clk_i,                    // oscillator clock
   input  wire logic        reset_n_i,                // async reset, active low
   input  wire logic        req_valid_i,              // core request for next cycle
   input  wire mebp_op_type req_kind_i,               // kind of machine cycle
   input  wire logic [11:0] req_addr_i,               // pc, data address or expander ctrl
   input  wire logic [7:0]  req_wdata_i,              // write data
   input  wire logic        instr_boundary_i,         // current cycle ends an instruction
   output logic             req_ready_o,              // request taken at the next edge
   output logic [7:0]       rdata_o,                  // read or fetched byte
   output logic             rdata_valid_o,            // one-cycle answer pulse
   input  wire logic [7:0]  rom_data_i,               // internal program byte
   output logic             halted_o,                 // stopped in single step
   input  wire logic        ss_n_i,                   // single step, active low
   input  wire logic        memory_source_select_i,   // high forces external fetch
   input  wire logic        irq_n_i,                  // interrupt pin, active low
   output logic             irq_request_o,            // interrupt requested
   output logic             jump_on_irq_low_o,        // irq pin low level
   input  wire logic        t0_i,                     // test zero pin in
   output logic             t0_o,                     // test zero pin out
   output logic             t0_oe_n_o,                // test zero drive, active low
   input  wire logic        clock_out_enable_op_i,    // pulse: clock onto test zero
   output logic             jump_on_test_zero_o,      // test zero level
   input  wire logic        t1_i,                     // test one pin
   input  wire logic        event_count_start_op_i,   // pulse: start counting
   input  wire logic        event_count_stop_i,       // pulse: stop counting
   output logic             jump_on_test_one_o,       // test one level
   output logic             event_tick_o,             // one pulse per counted edge
   input  wire logic        port_wr_i,                // write a port latch
   input  wire logic        port_sel_i,               // 0 port1, 1 port2
   input  wire logic [7:0]  port_wdata_i,             // port latch value
   output logic [7:0]       port1_in_o,               // port1 pin levels
   output logic [7:0]       port2_in_o,               // port2 pin levels
   output logic             ale_o,                    // address latch enable
   output logic             code_fetch_strobe_n_o,    // program fetch strobe
   output logic             rd_n_o,                   // read strobe
   output logic             wr_n_o,                   // write strobe
   output logic             expander_strobe_o,        // expander strobe
   input  wire logic [7:0]  d_i,                      // data bus in
   output logic [7:0]       d_o,                      // data bus out
   output logic             d_oe_n_o,                 // data bus drive, active low
   input  wire logic [7:0]  p1_i,                     // port1 pins in
   output logic [7:0]       p1_o,                     // port1 pins out
   output logic [7:0]       p1_oe_n_o,                // port1 drive per bit, active low
   input  wire logic [7:0]  p2_i,                     // port2 pins in
   output logic [7:0]       p2_o,                     // port2 pins out
   output logic [7:0]       p2_oe_n_o                 // port2 drive per bit, active low
);
   function automatic logic in_strobe(input logic [3:0] c);
      in_strobe = (c >= STB_ON) && (c < STB_OFF);
   endfunction
   mebp_state_type state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   mebp_op_type kind_reg, kind_next;
   logic        ext_reg, ext_next;
   logic        halt_req_reg, halt_req_next;
   logic        ready_reg, ready_next;
   logic [11:0] addr_reg, addr_next;
   logic [7:0]  wdata_reg, wdata_next;
   logic [7:0]  bus_latch_reg, bus_latch_next;
   logic        bus_hold_reg, bus_hold_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic [7:0]  p1_latch_reg, p1_latch_next;
   logic [7:0]  p2_latch_reg, p2_latch_next;
   logic        ale_reg, ale_next;
   logic        fstb_n_reg, fstb_n_next;
   logic        rd_n_reg, rd_n_next;
   logic        wr_n_reg, wr_n_next;
   logic        xstb_reg, xstb_next;
   logic [7:0]  d_reg, d_next;
   logic        d_oe_n_reg, d_oe_n_next;
   logic [7:0]  p2_out_reg, p2_out_next;
   logic [7:0]  p2_oe_n_reg, p2_oe_n_next;
   // sequencer, request capture and bus pins
   always_comb begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      kind_next      = kind_reg;
      ext_next       = ext_reg;
      halt_req_next  = halt_req_reg;
      ready_next     = 1'b0;
      addr_next      = addr_reg;
      wdata_next     = wdata_reg;
      bus_latch_next = bus_latch_reg;
      bus_hold_next  = bus_hold_reg;
      rdata_next     = rdata_reg;
      rvalid_next    = 1'b0;
      p1_latch_next  = p1_latch_reg;
      p2_latch_next  = p2_latch_reg;
      if (port_wr_i && !port_sel_i) begin
         p1_latch_next = port_wdata_i;
      end else if (port_wr_i) begin
         p2_latch_next = port_wdata_i;
      end
      case (state_reg)
         MEBP_ST_RUN: begin
            if (cnt_reg == CNT_DECIDE) begin
               halt_req_next = !ss_n_i && instr_boundary_i;        // [RULE3]
               cnt_next      = CNT_LAST;
               ready_next    = !(!ss_n_i && instr_boundary_i);
            end else if (cnt_reg == CNT_LAST) begin
               if (halt_req_reg) begin
                  state_next    = MEBP_ST_HALT;                    // [RULE3]
                  halt_req_next = 1'b0;
               end else begin
                  cnt_next  = 4'h0;
                  kind_next = MEBP_OP_IDLE;
                  ext_next  = 1'b0;
                  if (req_valid_i) begin
                     kind_next  = req_kind_i;
                     addr_next  = req_addr_i;
                     wdata_next = req_wdata_i;
                     ext_next   = (req_kind_i == MEBP_OP_FETCH) &&
                                  (memory_source_select_i ||
                                   (req_addr_i >= INT_ROM_LIMIT));  // [RULE5]
                     if (req_kind_i == MEBP_OP_BUS_OUT) begin
                        bus_latch_next = req_wdata_i;               // [RULE10]
                        bus_hold_next  = 1'b1;
                     end else if ((req_kind_i == MEBP_OP_DATA_RD) ||
                                  (req_kind_i == MEBP_OP_BUS_IN) ||
                                  ext_next) begin
                        bus_hold_next = 1'b0;                       // [RULE18]
                     end
                  end
               end
            end else begin
               cnt_next = cnt_reg + 4'h1;
            end
            if (cnt_reg == SAMPLE_AT) begin
               case (kind_reg)
                  MEBP_OP_FETCH: begin
                     rdata_next  = ext_reg ? d_i : rom_data_i;      // [RULE11]
                     rvalid_next = 1'b1;
                  end
                  MEBP_OP_DATA_RD, MEBP_OP_BUS_IN: begin
                     rdata_next  = d_i;                             // [RULE12]
                     rvalid_next = 1'b1;
                  end
                  MEBP_OP_EXP: begin
                     if (addr_reg[3:2] == EXP_CMD_READ) begin
                        rdata_next  = {4'h0, p2_i[3:0]};            // [RULE15]
                        rvalid_next = 1'b1;
                     end
                  end
                  default: rvalid_next = 1'b0;
               endcase
            end
         end
         MEBP_ST_HALT: begin
            if (ss_n_i) begin
               state_next = MEBP_ST_RUN;                            // [RULE3]
               ready_next = 1'b1;
            end
         end
         default: begin
            state_next = MEBP_ST_RUN;
            cnt_next   = 4'h0;
         end
      endcase
   end
   // pin levels for the phase that the next state enters
   always_comb begin
      ale_next     = 1'b0;
      fstb_n_next  = 1'b1;
      rd_n_next    = 1'b1;
      wr_n_next    = 1'b1;
      xstb_next    = 1'b1;
      d_next       = bus_latch_next;
      d_oe_n_next  = !bus_hold_next;                                 // [RULE10]
      p2_out_next  = p2_latch_next;
      p2_oe_n_next = p2_latch_next;                                  // [RULE13]
      if (state_next == MEBP_ST_HALT) begin
         ale_next = 1'b1;                                            // [RULE3]
      end else begin
         ale_next = (cnt_next < ALE_END);                            // [RULE9]
         case (kind_next)
            MEBP_OP_FETCH: begin
               if (ext_next) begin
                  p2_out_next[3:0]  = addr_next[11:8];               // [RULE14]
                  p2_oe_n_next[3:0] = 4'h0;
                  fstb_n_next       = !in_strobe(cnt_next);          // [RULE7]
                  if (cnt_next < ADDR_END) begin
                     d_next      = addr_next[7:0];                   // [RULE11]
                     d_oe_n_next = 1'b0;
                  end else begin
                     d_oe_n_next = 1'b1;                             // [RULE18]
                  end
               end
            end
            MEBP_OP_DATA_RD, MEBP_OP_BUS_IN: begin
               rd_n_next = !in_strobe(cnt_next);                     // [RULE6]
               if ((kind_next == MEBP_OP_DATA_RD) && (cnt_next < ADDR_END)) begin
                  d_next      = addr_next[7:0];                      // [RULE12]
                  d_oe_n_next = 1'b0;
               end else begin
                  d_oe_n_next = 1'b1;                                // [RULE18]
               end
            end
            MEBP_OP_DATA_WR, MEBP_OP_BUS_OUT: begin
               wr_n_next   = !in_strobe(cnt_next);                   // [RULE8]
               d_oe_n_next = 1'b0;
               if ((kind_next == MEBP_OP_DATA_WR) && (cnt_next < ADDR_END)) begin
                  d_next = addr_next[7:0];                           // [RULE12]
               end else begin
                  d_next = wdata_next;                               // [RULE10]
               end
            end
            MEBP_OP_EXP: begin
               xstb_next         = !in_strobe(cnt_next);             // [RULE16]
               p2_oe_n_next[3:0] = 4'h0;
               if (cnt_next < STB_ON) begin
                  p2_out_next[3:0] = addr_next[3:0];                 // [RULE15]
               end else if (addr_next[3:2] == EXP_CMD_READ) begin
                  p2_out_next[3:0]  = 4'hF;
                  p2_oe_n_next[3:0] = 4'hF;
               end else begin
                  p2_out_next[3:0] = wdata_next[3:0];                // [RULE15]
               end
            end
            default: ale_next = (cnt_next < ALE_END);
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg     <= MEBP_ST_RUN;
         cnt_reg       <= 4'h0;
         kind_reg      <= MEBP_OP_IDLE;
         ext_reg       <= 1'b0;
         halt_req_reg  <= 1'b0;
         ready_reg     <= 1'b0;
         addr_reg      <= 12'h000;
         wdata_reg     <= 8'h00;
         bus_latch_reg <= 8'h00;
         bus_hold_reg  <= 1'b0;
         rdata_reg     <= 8'h00;
         rvalid_reg    <= 1'b0;
         p1_latch_reg  <= PORT_RESET;                                // [RULE13]
         p2_latch_reg  <= PORT_RESET;
         ale_reg       <= 1'b1;
         fstb_n_reg    <= 1'b1;
         rd_n_reg      <= 1'b1;
         wr_n_reg      <= 1'b1;
         xstb_reg      <= 1'b1;
         d_reg         <= 8'h00;
         d_oe_n_reg    <= 1'b1;
         p2_out_reg    <= PORT_RESET;
         p2_oe_n_reg   <= PORT_RESET;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         kind_reg      <= kind_next;
         ext_reg       <= ext_next;
         halt_req_reg  <= halt_req_next;
         ready_reg     <= ready_next;
         addr_reg      <= addr_next;
         wdata_reg     <= wdata_next;
         bus_latch_reg <= bus_latch_next;
         bus_hold_reg  <= bus_hold_next;
         rdata_reg     <= rdata_next;
         rvalid_reg    <= rvalid_next;
         p1_latch_reg  <= p1_latch_next;
         p2_latch_reg  <= p2_latch_next;
         ale_reg       <= ale_next;
         fstb_n_reg    <= fstb_n_next;
         rd_n_reg      <= rd_n_next;
         wr_n_reg      <= wr_n_next;
         xstb_reg      <= xstb_next;
         d_reg         <= d_next;
         d_oe_n_reg    <= d_oe_n_next;
         p2_out_reg    <= p2_out_next;
         p2_oe_n_reg   <= p2_oe_n_next;
      end
   end
   // test pins, interrupt pin, event counting and port sampling
   logic        t0_lvl_reg, t0_lvl_next;
   logic        t1_lvl_reg, t1_lvl_next;
   logic        irq_reg, irq_next;
   logic        t0_oe_n_reg, t0_oe_n_next;
   logic        t0_out_reg, t0_out_next;
   logic [7:0]  div_reg, div_next;
   logic        count_en_reg, count_en_next;
   logic        tick_reg, tick_next;
   logic [7:0]  p1_in_reg, p1_in_next;
   logic [7:0]  p2_in_reg, p2_in_next;
   always_comb begin
      t0_lvl_next    = t0_i;                                         // [RULE1]
      t1_lvl_next    = t1_i;                                         // [RULE17]
      irq_next       = !irq_n_i;                                     // [RULE4]
      p1_in_next     = p1_i;
      p2_in_next     = p2_i;
      t0_oe_n_next   = t0_oe_n_reg && !clock_out_enable_op_i;        // [RULE2]
      t0_out_next    = t0_out_reg;
      div_next       = div_reg;
      if (!t0_oe_n_reg) begin
         if (div_reg == 8'(CLKOUT_DIV - 1)) begin
            div_next    = 8'h00;
            t0_out_next = !t0_out_reg;                               // [RULE2]
         end else begin
            div_next = div_reg + 8'h01;
         end
      end
      count_en_next = count_en_reg;
      if (event_count_start_op_i) begin
         count_en_next = 1'b1;
      end else if (event_count_stop_i) begin
         count_en_next = 1'b0;
      end
      tick_next = count_en_reg && t1_lvl_reg && !t1_i;               // [RULE17]
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         t0_lvl_reg    <= 1'b0;
         t1_lvl_reg    <= 1'b0;
         irq_reg       <= 1'b0;
         t0_oe_n_reg   <= 1'b1;
         t0_out_reg    <= 1'b0;
         div_reg       <= 8'h00;
         count_en_reg  <= 1'b0;
         tick_reg      <= 1'b0;
         p1_in_reg     <= 8'h00;
         p2_in_reg     <= 8'h00;
      end else begin
         t0_lvl_reg    <= t0_lvl_next;
         t1_lvl_reg    <= t1_lvl_next;
         irq_reg       <= irq_next;
         t0_oe_n_reg   <= t0_oe_n_next;
         t0_out_reg    <= t0_out_next;
         div_reg       <= div_next;
         count_en_reg  <= count_en_next;
         tick_reg      <= tick_next;
         p1_in_reg     <= p1_in_next;
         p2_in_reg     <= p2_in_next;
      end
   end
   assign req_ready_o           = ready_reg;
   assign rdata_o               = rdata_reg;
   assign rdata_valid_o         = rvalid_reg;
   assign halted_o              = (state_reg == MEBP_ST_HALT);
   assign irq_request_o         = irq_reg;
   assign jump_on_irq_low_o     = irq_reg;
   assign t0_o                  = t0_out_reg;
   assign t0_oe_n_o             = t0_oe_n_reg;
   assign jump_on_test_zero_o   = t0_lvl_reg;
   assign jump_on_test_one_o    = t1_lvl_reg;
   assign event_tick_o          = tick_reg;
   assign port1_in_o            = p1_in_reg;
   assign port2_in_o            = p2_in_reg;
   assign ale_o                 = ale_reg;
   assign code_fetch_strobe_n_o = fstb_n_reg;
   assign rd_n_o                = rd_n_reg;
   assign wr_n_o                = wr_n_reg;
   assign expander_strobe_o     = xstb_reg;
   assign d_o                   = d_reg;
   assign d_oe_n_o              = d_oe_n_reg;
   assign p1_o                  = p1_latch_reg;
   assign p1_oe_n_o             = p1_latch_reg;
   assign p2_o                  = p2_out_reg;
   assign p2_oe_n_o             = p2_oe_n_reg;
endmodule // mebp_external_bus_port

// ===== verification/mebp_ext_mem.sv
// external program and data memory on the multiplexed data bus
// assumes the bus port drives addresses with its latch strobe high and answers on read strobes
`timescale 1ns/1ps
module mebp_ext_mem (
   input  wire logic       clk_i,     // oscillator clock
   input  wire logic       ale_i,     // address latch enable
   input  wire logic       fstb_n_i,  // program fetch strobe
   input  wire logic       rd_n_i,    // read strobe
   input  wire logic       wr_n_i,    // write strobe
   input  wire logic       oe_n_i,    // port drives the bus
   input  wire logic [7:0] d_o_i,     // value driven by the port
   output logic      [7:0] d_i_o,     // resolved bus level
   output logic      [7:0] wr_byte_o  // last byte written
);
   logic [7:0] addr_reg;
   logic [7:0] last_reg = 8'h00;
   always @(posedge clk_i) begin
      if (ale_i && !oe_n_i) addr_reg <= d_o_i;
      if (!wr_n_i) wr_byte_o <= d_o_i;
      last_reg <= d_i_o;
   end
   // contents are address plus 8'h11; floating bus toggles each cycle
   always_comb begin
      if (!oe_n_i) d_i_o = d_o_i;
      else if (!fstb_n_i || !rd_n_i) d_i_o = addr_reg + 8'h11;
      else d_i_o = ~last_reg;
   end
endmodule // mebp_ext_mem

// ===== verification/mebp_chk.sv
// assertions on strobes, latch enable, bus drive and the test zero pin copy
// assumes binding onto mebp_external_bus_port, one clock domain
`timescale 1ns/1ps
module mebp_chk (
   input wire logic clk_i, reset_n_i, ale_o, rdata_valid_o, halted_o,
   input wire logic code_fetch_strobe_n_o, rd_n_o, wr_n_o, expander_strobe_o, d_oe_n_o,
   input wire logic irq_n_i, irq_request_o, t0_i, jump_on_test_zero_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_excl; $countones({!code_fetch_strobe_n_o, !rd_n_o, !wr_n_o}) <= 1; endproperty
   a_excl: assert property (p_excl) else $error("strobes overlap");
   property p_release; (!rd_n_o || !code_fetch_strobe_n_o) |-> d_oe_n_o; endproperty
   a_release: assert property (p_release) else $error("bus driven in read");
   property p_ale_width; $rose(ale_o) && !halted_o |-> ale_o[*4] ##1 !ale_o; endproperty
   a_ale_width: assert property (p_ale_width) else $error("latch pulse width");
   property p_ale_period; $fell(ale_o) && !$past(halted_o) |-> ##11 ale_o; endproperty
   a_ale_period: assert property (p_ale_period) else $error("latch period");
   property p_rd; $fell(rd_n_o) |-> (!rd_n_o && !ale_o)[*7] ##1 (rd_n_o && rdata_valid_o);
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe shape");
   property p_fetch; $fell(code_fetch_strobe_n_o) |-> (!code_fetch_strobe_n_o)[*7]
      ##1 rdata_valid_o ##2 ale_o; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch strobe shape");
   property p_wr; $fell(wr_n_o) |-> (!wr_n_o && !d_oe_n_o && !ale_o)[*7] ##1 wr_n_o; endproperty
   a_wr: assert property (p_wr) else $error("write strobe shape");
   property p_exp; $fell(expander_strobe_o) |-> (!expander_strobe_o)[*7] ##1 expander_strobe_o;
   endproperty
   a_exp: assert property (p_exp) else $error("expander strobe shape");
   property p_irq; $fell(irq_n_i) |=> irq_request_o; endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
   property p_t0; $changed(t0_i) |=> jump_on_test_zero_o == $past(t0_i); endproperty
   a_t0: assert property (p_t0) else $error("test zero copy");
   property p_halt; halted_o |-> ale_o && rd_n_o && wr_n_o && code_fetch_strobe_n_o; endproperty
   a_halt: assert property (p_halt) else $error("activity while halted");
   c_rd: cover property ($fell(rd_n_o));
   c_wr: cover property ($fell(wr_n_o));
   c_fetch: cover property ($fell(code_fetch_strobe_n_o));
   c_halt: cover property ($rose(halted_o));
endmodule // mebp_chk
bind mebp_external_bus_port mebp_chk mebp_chk_i (.*);

// ===== verification/tb_top.sv
// self-checking bench: request rows, bus output, expander, ports, test pins, single step
// assumes mebp_ext_mem on the data bus, 8'h3C outside port1, and ones outside port2 except 9 on its low nibble during expander strobe
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   import mebp_pkg::*;
   localparam int DIV = 2;
   typedef struct {mebp_op_type k; logic [11:0] a; logic [7:0] w; logic s; logic [7:0] e;}
      mebp_row_type;
   mebp_row_type rows [7] = '{'{MEBP_OP_FETCH, 12'h012, 8'h00, 1'b0, 8'hC3},
      '{MEBP_OP_FETCH, 12'h012, 8'h00, 1'b1, 8'h23}, '{MEBP_OP_FETCH, 12'h834, 8'h00, 1'b0, 8'h45},
      '{MEBP_OP_DATA_RD, 12'h056, 8'h00, 1'b0, 8'h67}, '{MEBP_OP_BUS_IN, 12'h000, 8'h00, 1'b0, 8'h67},
      '{MEBP_OP_DATA_WR, 12'h078, 8'h5A, 1'b0, 8'h00}, '{MEBP_OP_BUS_OUT, 12'h000, 8'h96, 1'b0, 8'h00}};
   logic clk_i = 0, reset_n_i = 0, req_valid_i = 0, ss_n_i = 1, memory_source_select_i = 0;
   logic irq_n_i = 1, t0_i = 1, t1_i = 1, clock_out_enable_op_i = 0, event_count_start_op_i = 0;
   logic event_count_stop_i = 0, port_wr_i = 0, port_sel_i = 0, instr_boundary_i = 1;
   mebp_op_type req_kind_i = MEBP_OP_IDLE;
   logic [11:0] req_addr_i = 12'h000;
   logic [7:0]  req_wdata_i = 8'h00, port_wdata_i = 8'h00, rom_data_i = 8'hC3, p1_ext = 8'h3C;
   logic req_ready_o, rdata_valid_o, halted_o, irq_request_o, jump_on_irq_low_o, t0_o, t0_oe_n_o;
   logic jump_on_test_zero_o, jump_on_test_one_o, event_tick_o, ale_o, code_fetch_strobe_n_o;
   logic rd_n_o, wr_n_o, expander_strobe_o, d_oe_n_o, fstb_seen, ext, tck;
   logic [7:0] rdata_o, port1_in_o, port2_in_o, d_i, d_o, p1_o, p1_oe_n_o, p2_o, p2_oe_n_o;
   logic [7:0] p1_i, p2_i, p2_ext, wr_byte;
   logic [3:0] exp_nib;
   int tests_run = 0, miscompares = 0, cycles = 0, ticks = 0, n;
   // quasi pins: driven bits show the port value, released bits the outside level
   assign p2_ext = {4'hF, expander_strobe_o ? 4'hF : 4'h9};
   assign p1_i = (~p1_oe_n_o & p1_o) | (p1_oe_n_o & p1_ext);
   assign p2_i = (~p2_oe_n_o & p2_o) | (p2_oe_n_o & p2_ext);
   mebp_external_bus_port #(.CLKOUT_DIV(DIV)) mebp_external_bus_port_i (.*);
   mebp_ext_mem mebp_ext_mem_i (.clk_i(clk_i), .ale_i(ale_o), .fstb_n_i(code_fetch_strobe_n_o),
      .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .oe_n_i(d_oe_n_o), .d_o_i(d_o), .d_i_o(d_i),
      .wr_byte_o(wr_byte));
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (code_fetch_strobe_n_o === 1'b0) fstb_seen <= 1'b1;
      if (expander_strobe_o === 1'b0) exp_nib <= p2_i[3:0];
      if (event_tick_o === 1'b1) ticks <= ticks + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic do_req(input mebp_op_type k, input logic [11:0] a, input logic [7:0] w);
      for (n = 0; n < 40 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
      req_valid_i = 1;
      req_kind_i = k;
      req_addr_i = a;
      req_wdata_i = w;
      @(negedge clk_i);
      req_valid_i = 0;
      if (k inside {MEBP_OP_DATA_WR, MEBP_OP_BUS_OUT} || (k == MEBP_OP_EXP && a[3:2] != 2'h0))
         repeat (14) @(negedge clk_i);
      else for (n = 0; n < 20 && rdata_valid_o !== 1'b1; n++) @(negedge clk_i);
   endtask
   task automatic step(input int c);
      repeat (c) @(negedge clk_i);
   endtask
   initial begin
      step(20);
      `CHK("ale_rst", 1'b1, ale_o)
      `CHK("p1oe_rst", 8'hFF, p1_oe_n_o)
      `CHK("doe_rst", 1'b1, d_oe_n_o)
      `CHK("t0oe_rst", 1'b1, t0_oe_n_o)
      reset_n_i = 1;
      step(3);
      `CHK("p1_in", 8'h3C, port1_in_o)
      `CHK("p2_in", 8'hFF, port2_in_o)
      port_wr_i = 1;
      port_wdata_i = 8'h0F;
      step(1);
      port_sel_i = 1;
      step(1);
      port_wr_i = 0;
      step(3);
      `CHK("p1_out", 8'h0C, port1_in_o)
      `CHK("p2_out", 8'h0F, port2_in_o)
      port_wr_i = 1;
      port_sel_i = 0;
      port_wdata_i = 8'hFF;
      step(1);
      port_wr_i = 0;
      step(3);
      `CHK("p1_ones", 8'h3C, port1_in_o)
      irq_n_i = 0;
      t0_i = 0;
      t1_i = 0;
      step(2);
      `CHK("irq", 2'b11, {irq_request_o, jump_on_irq_low_o})
      `CHK("t0", 1'b0, jump_on_test_zero_o)
      `CHK("t1", 1'b0, jump_on_test_one_o)
      irq_n_i = 1;
      t0_i = 1;
      t1_i = 1;
      event_count_start_op_i = 1;
      step(1);
      event_count_start_op_i = 0;
      t1_i = 0;
      step(3);
      event_count_stop_i = 1;
      t1_i = 1;
      step(1);
      event_count_stop_i = 0;
      step(2);
      t1_i = 0;
      step(3);
      `CHK("ticks", 1, ticks)
      foreach (rows[i]) begin
         memory_source_select_i = rows[i].s;
         fstb_seen = 0;
         do_req(rows[i].k, rows[i].a, rows[i].w);
         ext = rows[i].k == MEBP_OP_FETCH && (rows[i].s || rows[i].a >= INT_ROM_LIMIT);
         if (rows[i].k inside {MEBP_OP_DATA_WR, MEBP_OP_BUS_OUT})
            `CHK("wbyte", rows[i].w, wr_byte)
         else
            `CHK("rdata", rows[i].e, rdata_o)
         `CHK("fstb", ext, fstb_seen)
         if (ext) `CHK("p2_pc", rows[i].a[11:8], p2_i[3:0])
      end
      memory_source_select_i = 0;
      step(20);
      `CHK("bus_hold", 9'h096, {d_oe_n_o, d_o})
      do_req(MEBP_OP_DATA_RD, 12'h056, 8'h00);
      `CHK("rd_after", 8'h67, rdata_o)
      step(20);
      `CHK("bus_free", 1'b1, d_oe_n_o)
      do_req(MEBP_OP_EXP, 12'h001, 8'h00);
      `CHK("exp_rd", 4'h9, rdata_o[3:0])
      do_req(MEBP_OP_EXP, 12'h006, 8'h05);
      `CHK("exp_wr", 4'h5, exp_nib)
      ss_n_i = 0;
      for (n = 0; n < 60 && halted_o !== 1'b1; n++) @(negedge clk_i);
      step(20);
      `CHK("halt", 2'b11, {halted_o, ale_o})
      ss_n_i = 1;
      step(2);
      `CHK("unhalt", 1'b0, halted_o)
      clock_out_enable_op_i = 1;
      step(1);
      clock_out_enable_op_i = 0;
      step(4);
      tck = t0_o;
      step(DIV);
      `CHK("t0_clk", {1'b0, ~tck}, {t0_oe_n_o, t0_o})
      close_out();
   end
endmodule // tb_top
